// ### hbp_pkg.sv
// Shared constants and types for the parallel host port
package hbp_pkg;

    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int DATA_W    = 32;
    localparam int LANE_W    = 8;
    localparam int LANES     = 4;
    localparam int HALF_W    = 16;
    localparam int ADDR_W    = 11;
    localparam int WADDR_W   = 9;
    localparam int WORDS     = 512;
    localparam int LANE_IDX_W = 2;

    // ----------------------------------------
    // Data enables per width
    // ----------------------------------------
    localparam logic [DATA_W-1:0] MASK32 = 32'hffffffff;
    localparam logic [DATA_W-1:0] MASK16 = 32'h0000ffff;
    localparam logic [DATA_W-1:0] MASK8  = 32'h000000ff;

    // ----------------------------------------
    // Bus width modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        HBP_W8  = 2'h0,
        HBP_W16 = 2'h1,
        HBP_W32 = 2'h2
    } hbp_width_e;

    function automatic hbp_width_e hbp_width(input logic hi, input logic lo);
        return hi ? HBP_W32 : (lo ? HBP_W16 : HBP_W8);
    endfunction

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS       = 25;
    localparam int T_ACC_NS     = 300;
    localparam int T_GAP_NS     = 100;
    localparam int RST_WAIT_TXI = 20;
    localparam int CNT_W        = 5;
    localparam logic [CNT_W-1:0] ACC_CYC =
        CNT_W'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] GAP_CYC =
        CNT_W'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RST_WAIT_CYC = CNT_W'(RST_WAIT_TXI);
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

endpackage

// ### hbp_if.sv
// Pin-level carrier between the user CPU end and the device end
`timescale 1ns/1ps
`default_nettype none

interface hbp_if;

    // ----------------------------------------
    // Control and address pins
    // ----------------------------------------
    logic                       cs_n;
    logic                       rd_n;
    logic                       lane0_write_strobe_n;
    logic                       lane1_strobe_or_addr_bit0;
    logic                       lane2_strobe_or_addr_bit1;
    logic                       lane3_strobe_or_endian_sel;
    logic [hbp_pkg::WADDR_W-1:0] addr_hi;
    logic                       width_select_low;
    logic                       width_select_high;

    // ----------------------------------------
    // Data bus drivers and resolved level
    // ----------------------------------------
    logic [hbp_pkg::DATA_W-1:0] host_data;
    logic [hbp_pkg::DATA_W-1:0] host_data_oe;
    logic [hbp_pkg::DATA_W-1:0] dev_data;
    logic [hbp_pkg::DATA_W-1:0] dev_data_oe;
    logic [hbp_pkg::DATA_W-1:0] data_bus;

    // Pull-up when nobody drives
    assign data_bus = (dev_data_oe & dev_data) | (host_data_oe & ~dev_data_oe & host_data)
                    | ~(dev_data_oe | host_data_oe);

    modport host (
        output cs_n, rd_n, lane0_write_strobe_n, lane1_strobe_or_addr_bit0,
        output lane2_strobe_or_addr_bit1, lane3_strobe_or_endian_sel, addr_hi,
        output width_select_low, width_select_high, host_data, host_data_oe,
        input  data_bus
    );

    modport device (
        input  cs_n, rd_n, lane0_write_strobe_n, lane1_strobe_or_addr_bit0,
        input  lane2_strobe_or_addr_bit1, lane3_strobe_or_endian_sel, addr_hi,
        input  width_select_low, width_select_high, data_bus,
        output dev_data, dev_data_oe
    );

endinterface

`default_nettype wire

// ### hbp_device.sv
// Device end of the parallel host port with its shared memory
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Upper width select high gives 32-bit bus
// - Lower high, upper low gives 16-bit bus
// - Both selects low gives 8-bit bus
// - Shared pins change role with width
// - 32-bit: first shared pin strobes lane 3
// - 32-bit: second shared pin strobes lane 2
// - 32/16-bit: third shared pin strobes lane 1
// - Dedicated strobe always gates lane 0
// - Narrow modes: first shared pin selects endian
// - Narrow modes: second shared pin is A1
// - 8-bit only: third shared pin is A0
// - Address bits 2 to 10 always dedicated
// - Data moves on the mode's active bits
// - Host ties unused upper data bits low
// - Half-word host pairs its strobes; the 16-bit host here drives each strobe from its own req_be bit
// - Word-only host drives all strobes; the 32-bit host here drives only the strobes set in req_be
// - Host makes chip select from decode; the host here drives it low for the whole HBP_ACC state
// - Host stretches cycles to access time
// - Read only while select and read low
// - Write stored when select returns high
// - Host spaces accesses at least five clocks apart
// - Host waits twenty clocks after reset
module hbp_device (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        nrst,
    // Host pins
    hbp_if.device                            bus,
    // Local user port
    input  wire logic [hbp_pkg::WADDR_W-1:0] user_addr,
    output logic      [hbp_pkg::DATA_W-1:0]  user_rdata,
    output logic                             user_wr_pulse,
    output logic      [hbp_pkg::WADDR_W-1:0] user_wr_addr,
    output logic      [1:0]                  user_mode
);

    // ----------------------------------------
    // Input filter
    // ----------------------------------------
    localparam int IN_W = 2 + 6 + hbp_pkg::WADDR_W + hbp_pkg::DATA_W;
    localparam logic [IN_W-1:0] IN_RST = {2'h0, 6'h3f, 9'h000, 32'h00000000};

    logic [IN_W-1:0] pin_in;
    logic [IN_W-1:0] s1_reg;
    logic [IN_W-1:0] s2_reg;
    logic [IN_W-1:0] s3_reg;
    logic [IN_W-1:0] f_reg;

    assign pin_in = {bus.width_select_high, bus.width_select_low,
                     bus.cs_n, bus.rd_n, bus.lane0_write_strobe_n,
                     bus.lane3_strobe_or_endian_sel, bus.lane2_strobe_or_addr_bit1,
                     bus.lane1_strobe_or_addr_bit0, bus.addr_hi, bus.data_bus};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_reg <= IN_RST;
            s2_reg <= IN_RST;
            s3_reg <= IN_RST;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < IN_W; gi++) begin : g_filt
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    f_reg[gi] <= IN_RST[gi];
                end else if (s2_reg[gi] == s3_reg[gi]) begin
                    f_reg[gi] <= s3_reg[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Pin decode
    // ----------------------------------------
    logic                        f_wsh;
    logic                        f_wsl;
    logic                        f_cs_n;
    logic                        f_rd_n;
    logic                        f_wr0_n;
    logic                        f_p3;
    logic                        f_p2;
    logic                        f_p1;
    logic [hbp_pkg::WADDR_W-1:0] f_addr;
    logic [hbp_pkg::DATA_W-1:0]  f_data;

    assign {f_wsh, f_wsl, f_cs_n, f_rd_n, f_wr0_n, f_p3, f_p2, f_p1, f_addr, f_data} = f_reg;

    hbp_pkg::hbp_width_e mode;
    assign mode = hbp_pkg::hbp_width(f_wsh, f_wsl);

    logic is32;
    logic is16;
    logic is8;
    assign is32 = (mode == hbp_pkg::HBP_W32);
    assign is16 = (mode == hbp_pkg::HBP_W16);
    assign is8  = (mode == hbp_pkg::HBP_W8);

    logic [hbp_pkg::LANES-1:0] stb;
    assign stb[0] = ~f_wr0_n;
    assign stb[1] = (is32 | is16) & ~f_p1;
    assign stb[2] = is32 & ~f_p2;
    assign stb[3] = is32 & ~f_p3;

    logic big;
    logic a1;
    logic a0;
    assign big = ~is32 & f_p3;
    assign a1  = ~is32 & f_p2;
    assign a0  = is8 & f_p1;

    logic                               half_sel;
    logic [hbp_pkg::LANE_IDX_W-1:0]     byte_lane;
    logic [hbp_pkg::LANES-1:0]          byte_hot;
    assign half_sel  = a1 ^ big;
    assign byte_lane = {a1, a0} ^ {big, big};
    assign byte_hot  = 4'(4'h1 << byte_lane);

    // ----------------------------------------
    // Write lane mapping
    // ----------------------------------------
    logic [hbp_pkg::LANES-1:0]  wmask;
    logic [hbp_pkg::DATA_W-1:0] wdata;
    assign wmask = is32 ? stb
                 : is16 ? (half_sel ? {stb[1:0], 2'h0} : {2'h0, stb[1:0]})
                 : (byte_hot & {hbp_pkg::LANES{stb[0]}});
    assign wdata = is32 ? f_data
                 : is16 ? {2{f_data[hbp_pkg::HALF_W-1:0]}}
                 : {hbp_pkg::LANES{f_data[hbp_pkg::LANE_W-1:0]}};

    // ----------------------------------------
    // Shared memory, one array per lane
    // ----------------------------------------
    logic                        commit;
    logic                        pend_reg;
    logic [hbp_pkg::LANES-1:0]   mask_reg;
    logic [hbp_pkg::DATA_W-1:0]  wdata_reg;
    logic [hbp_pkg::WADDR_W-1:0] waddr_reg;
    logic [hbp_pkg::DATA_W-1:0]  q;
    logic [hbp_pkg::DATA_W-1:0]  uq;

    generate
        for (gi = 0; gi < hbp_pkg::LANES; gi++) begin : g_lane
            logic [hbp_pkg::LANE_W-1:0] lane_mem [hbp_pkg::WORDS];
            always_ff @(posedge clk) begin
                if (commit && mask_reg[gi]) begin
                    lane_mem[waddr_reg] <= wdata_reg[gi*hbp_pkg::LANE_W +: hbp_pkg::LANE_W];
                end
            end
            assign q[gi*hbp_pkg::LANE_W +: hbp_pkg::LANE_W]  = lane_mem[f_addr];
            assign uq[gi*hbp_pkg::LANE_W +: hbp_pkg::LANE_W] = lane_mem[user_addr];
        end
    endgenerate

    // ----------------------------------------
    // Access recognition
    // ----------------------------------------
    logic cs_act;
    logic rd_act;
    logic wr_act;
    assign cs_act = ~f_cs_n;
    assign rd_act = cs_act & ~f_rd_n;
    assign wr_act = cs_act & |wmask;
    assign commit = pend_reg & ~cs_act;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pend_reg  <= 1'b0;
            mask_reg  <= '0;
            wdata_reg <= '0;
            waddr_reg <= '0;
        end else if (wr_act) begin
            pend_reg  <= 1'b1;
            mask_reg  <= mask_reg | wmask;
            wdata_reg <= wdata;
            waddr_reg <= f_addr;
        end else if (commit) begin
            pend_reg  <= 1'b0;
            mask_reg  <= '0;
        end
    end

    // ----------------------------------------
    // Read data path
    // ----------------------------------------
    logic [hbp_pkg::DATA_W-1:0] rd_fmt;
    logic [hbp_pkg::DATA_W-1:0] rd_oe;
    logic [hbp_pkg::DATA_W-1:0] rdata_reg;
    logic [hbp_pkg::DATA_W-1:0] oe_reg;

    assign rd_fmt = is32 ? q
                  : is16 ? {16'h0000, half_sel ? q[31:16] : q[15:0]}
                  : {24'h000000, q[byte_lane*hbp_pkg::LANE_W +: hbp_pkg::LANE_W]};
    assign rd_oe  = !rd_act ? '0
                  : is32 ? hbp_pkg::MASK32
                  : is16 ? hbp_pkg::MASK16
                  : hbp_pkg::MASK8;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_reg <= '0;
            oe_reg    <= '0;
        end else begin
            rdata_reg <= rd_fmt;
            oe_reg    <= rd_oe;
        end
    end

    assign bus.dev_data    = rdata_reg;
    assign bus.dev_data_oe = oe_reg;

    // ----------------------------------------
    // Local user port
    // ----------------------------------------
    logic [hbp_pkg::DATA_W-1:0]  urd_reg;
    logic                        uwp_reg;
    logic [hbp_pkg::WADDR_W-1:0] uwa_reg;
    logic [1:0]                  umode_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            urd_reg   <= '0;
            uwp_reg   <= 1'b0;
            uwa_reg   <= '0;
            umode_reg <= hbp_pkg::HBP_W8;
        end else begin
            urd_reg   <= uq;
            uwp_reg   <= commit;
            uwa_reg   <= commit ? waddr_reg : uwa_reg;
            umode_reg <= mode;
        end
    end

    assign user_rdata    = urd_reg;
    assign user_wr_pulse = uwp_reg;
    assign user_wr_addr  = uwa_reg;
    assign user_mode     = umode_reg;

endmodule // hbp_device

`default_nettype wire

// ### hbp_host.sv
// User CPU end of the parallel host port
`timescale 1ns/1ps
`default_nettype none

module hbp_host (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       nrst,
    // Static configuration
    input  wire logic                       cfg_width_high,
    input  wire logic                       cfg_width_low,
    input  wire logic                       cfg_big_endian,
    // Request
    input  wire logic                       req_valid,
    output logic                            req_ready,
    input  wire logic                       req_write,
    input  wire logic [hbp_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [hbp_pkg::LANES-1:0]  req_be,
    input  wire logic [hbp_pkg::DATA_W-1:0] req_wdata,
    // Response
    output logic                            rsp_valid,
    output logic      [hbp_pkg::DATA_W-1:0] rsp_rdata,
    // Device pins
    hbp_if.host                             bus
);

    // ----------------------------------------
    // Straps and mode
    // ----------------------------------------
    logic wsh_reg;
    logic wsl_reg;
    logic big_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wsh_reg <= 1'b0;
            wsl_reg <= 1'b0;
            big_reg <= 1'b0;
        end else begin
            wsh_reg <= cfg_width_high;
            wsl_reg <= cfg_width_low;
            big_reg <= cfg_big_endian;
        end
    end

    hbp_pkg::hbp_width_e mode;
    assign mode = hbp_pkg::hbp_width(wsh_reg, wsl_reg);

    logic [hbp_pkg::DATA_W-1:0] act_mask;
    assign act_mask = (mode == hbp_pkg::HBP_W32) ? hbp_pkg::MASK32
                    : (mode == hbp_pkg::HBP_W16) ? hbp_pkg::MASK16 : hbp_pkg::MASK8;

    // ----------------------------------------
    // Read data filter
    // ----------------------------------------
    logic [hbp_pkg::DATA_W-1:0] d1_reg;
    logic [hbp_pkg::DATA_W-1:0] d2_reg;
    logic [hbp_pkg::DATA_W-1:0] d3_reg;
    logic [hbp_pkg::DATA_W-1:0] df_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            d1_reg <= '0;
            d2_reg <= '0;
            d3_reg <= '0;
        end else begin
            d1_reg <= bus.data_bus;
            d2_reg <= d1_reg;
            d3_reg <= d2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < hbp_pkg::DATA_W; gi++) begin : g_filt
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    df_reg[gi] <= 1'b0;
                end else if (d2_reg[gi] == d3_reg[gi]) begin
                    df_reg[gi] <= d3_reg[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    typedef enum logic [1:0] {
        HBP_INIT = 2'h0,
        HBP_IDLE = 2'h1,
        HBP_ACC  = 2'h3,
        HBP_GAP  = 2'h2
    } hbp_state_e;

    hbp_state_e                  st_reg;
    logic [hbp_pkg::CNT_W-1:0]   cnt_reg;
    logic                        we_reg;
    logic [hbp_pkg::ADDR_W-1:0]  addr_reg;
    logic [hbp_pkg::LANES-1:0]   be_reg;
    logic [hbp_pkg::DATA_W-1:0]  wd_reg;
    logic [hbp_pkg::DATA_W-1:0]  rd_reg;
    logic                        rv_reg;

    logic start;
    logic cnt_end;
    assign req_ready = (st_reg == HBP_IDLE);
    assign start     = req_ready & req_valid;
    assign cnt_end   = (cnt_reg == hbp_pkg::CNT_ONE);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg  <= HBP_INIT;
            cnt_reg <= hbp_pkg::RST_WAIT_CYC;
            rv_reg  <= 1'b0;
        end else begin
            rv_reg <= (st_reg == HBP_ACC) & cnt_end;
            unique case (st_reg)
                HBP_INIT: begin
                    cnt_reg <= cnt_reg - hbp_pkg::CNT_ONE;
                    st_reg  <= cnt_end ? HBP_IDLE : HBP_INIT;
                end
                HBP_IDLE: begin
                    cnt_reg <= hbp_pkg::ACC_CYC;
                    st_reg  <= start ? HBP_ACC : HBP_IDLE;
                end
                HBP_ACC: begin
                    cnt_reg <= cnt_end ? hbp_pkg::GAP_CYC : cnt_reg - hbp_pkg::CNT_ONE;
                    st_reg  <= cnt_end ? HBP_GAP : HBP_ACC;
                end
                HBP_GAP: begin
                    cnt_reg <= cnt_reg - hbp_pkg::CNT_ONE;
                    st_reg  <= cnt_end ? HBP_IDLE : HBP_GAP;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            we_reg   <= 1'b0;
            addr_reg <= '0;
            be_reg   <= '0;
            wd_reg   <= '0;
            rd_reg   <= '0;
        end else begin
            if (start) begin
                we_reg   <= req_write;
                addr_reg <= req_addr;
                be_reg   <= req_be;
                wd_reg   <= req_wdata & act_mask;
            end
            if ((st_reg == HBP_ACC) && cnt_end && !we_reg) begin
                rd_reg <= df_reg & act_mask;
            end
        end
    end

    assign rsp_valid = rv_reg;
    assign rsp_rdata = rd_reg;

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    logic                      in_acc;
    logic [hbp_pkg::LANES-1:0] stb;
    assign in_acc = (st_reg == HBP_ACC);
    assign stb    = {hbp_pkg::LANES{in_acc & we_reg}} & be_reg;

    assign bus.cs_n                 = ~in_acc;
    assign bus.rd_n                 = ~(in_acc & ~we_reg);
    assign bus.lane0_write_strobe_n = ~stb[0];
    assign bus.lane3_strobe_or_endian_sel =
        (mode == hbp_pkg::HBP_W32) ? ~stb[3] : big_reg;
    assign bus.lane2_strobe_or_addr_bit1 =
        (mode == hbp_pkg::HBP_W32) ? ~stb[2] : addr_reg[1];
    assign bus.lane1_strobe_or_addr_bit0 =
        (mode == hbp_pkg::HBP_W8) ? addr_reg[0] : ~stb[1];
    assign bus.addr_hi           = addr_reg[hbp_pkg::ADDR_W-1:2];
    assign bus.width_select_high = wsh_reg;
    assign bus.width_select_low  = wsl_reg;
    assign bus.host_data    = wd_reg;
    assign bus.host_data_oe = ~act_mask | ({hbp_pkg::DATA_W{in_acc & we_reg}} & act_mask);

endmodule // hbp_host

`default_nettype wire

// ### hbp_chk.sv
// Pin-level checker for the parallel host port
`timescale 1ns/1ps
`default_nettype none

module hbp_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // Host pins
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        lane1_strobe_or_addr_bit0,
    input wire logic        lane2_strobe_or_addr_bit1,
    input wire logic        lane3_strobe_or_endian_sel,
    input wire logic [8:0]  addr_hi,
    input wire logic        width_select_low,
    input wire logic        width_select_high,
    // Data bus
    input wire logic [31:0] host_data,
    input wire logic [31:0] dev_data_oe
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [31:0] mode_mask;
    logic [4:0]  rst_cnt_reg;
    logic [4:0]  rst_cnt_next;
    assign mode_mask = width_select_high ? hbp_pkg::MASK32
                     : (width_select_low ? hbp_pkg::MASK16 : hbp_pkg::MASK8);
    assign rst_cnt_next = !nrst ? 5'h00 : rst_cnt_reg + {4'h0, rst_cnt_reg != 5'h1f};
    always_ff @(posedge clk) begin
        rst_cnt_reg <= rst_cnt_next;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_IDLE_NODRV: assert property ((cs_n || rd_n)[*8] |-> dev_data_oe == 32'h0)
        else $error("device drives bus outside a read");
    AST_RD_DRIVE: assert property ((!cs_n && !rd_n)[*8] |->
        dev_data_oe == mode_mask)
        else $error("read drive width differs from mode");
    AST_OE_MASK: assert property ((dev_data_oe & ~mode_mask) == 32'h0)
        else $error("device drives bits beyond mode width");
    AST_UNUSED_LOW: assert property (!cs_n |-> (host_data & ~mode_mask) == 32'h0)
        else $error("unused upper data not held low");
    AST_GAP: assert property ($rose(cs_n) |-> cs_n[*3])
        else $error("access gap too short");
    AST_ACC_LEN: assert property ($fell(cs_n) |-> (!cs_n)[*8] ##1 (!cs_n)[*4] ##1 cs_n)
        else $error("access window length wrong");
    AST_RST_WAIT: assert property (rst_cnt_reg < 5'h14 |-> cs_n)
        else $error("access too soon after reset");
    AST_STRAP_STABLE: assert property (!cs_n |->
        $stable({width_select_high, width_select_low}))
        else $error("width straps moved during access");
    AST_ENDIAN_STATIC: assert property ((!cs_n && !width_select_high) |->
        $stable(lane3_strobe_or_endian_sel))
        else $error("endian select moved during access");
    AST_PINS_HOLD: assert property ((!$past(cs_n) && !cs_n) |->
        $stable({addr_hi, lane2_strobe_or_addr_bit1, lane1_strobe_or_addr_bit0}))
        else $error("address pins moved during access");

    // ----------------------------------------
    // Covers
    // ----------------------------------------
    cover property ((!cs_n && !rd_n)[*8]);
    cover property ($fell(cs_n) && rd_n);
    cover property ($fell(cs_n) && !width_select_high && !width_select_low);

endmodule // hbp_chk

`default_nettype wire

// ### tb.sv
// Self-checking bench for both ends of the host port
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ----------------------------------------
    // Stimulus and observation
    // ----------------------------------------
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        hi = 1'b1;
    logic        lo = 1'b0;
    logic        en = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [10:0] req_addr = 11'h000;
    logic [3:0]  req_be = 4'h0;
    logic [31:0] req_wdata = 32'h0;
    logic [8:0]  user_addr = 9'h000;
    logic        req_ready, rsp_valid, user_wr_pulse;
    logic [31:0] rsp_rdata, user_rdata;
    logic [8:0]  user_wr_addr;
    logic [1:0]  user_mode;
    logic [31:0] exp_mem [512];
    int          errors = 0;
    int          checks_done = 0;
    int          cyc = 0;

    hbp_if bus_if ();
    hbp_host hbp_host_i (.clk(clk), .nrst(nrst), .cfg_width_high(hi), .cfg_width_low(lo),
        .cfg_big_endian(en), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus(bus_if));
    hbp_device hbp_device_i (.clk(clk), .nrst(nrst), .bus(bus_if), .user_addr(user_addr),
        .user_rdata(user_rdata), .user_wr_pulse(user_wr_pulse), .user_wr_addr(user_wr_addr),
        .user_mode(user_mode));
    hbp_chk hbp_chk_i (.clk(clk), .nrst(nrst), .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n),
        .lane1_strobe_or_addr_bit0(bus_if.lane1_strobe_or_addr_bit0),
        .lane2_strobe_or_addr_bit1(bus_if.lane2_strobe_or_addr_bit1),
        .lane3_strobe_or_endian_sel(bus_if.lane3_strobe_or_endian_sel),
        .addr_hi(bus_if.addr_hi), .width_select_low(bus_if.width_select_low),
        .width_select_high(bus_if.width_select_high), .host_data(bus_if.host_data),
        .dev_data_oe(bus_if.dev_data_oe));

    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end

    // ----------------------------------------
    // Expectation model
    // ----------------------------------------
    function automatic void model_wr(logic [10:0] a, logic [3:0] be, logic [31:0] d);
        logic [1:0] b;
        for (int i = 0; i < 4; i++) begin
            b = hi ? 2'(i) : (lo ? {a[1] ^ en, 1'(i)} : (a[1:0] ^ {en, en}));
            if (be[i] && (hi || (lo && i < 2) || i == 0)) begin
                exp_mem[a[10:2]][8*b +: 8] = d[8*i +: 8];
            end
        end
    endfunction

    function automatic logic [31:0] model_rd(logic [10:0] a);
        logic [31:0] w;
        w = exp_mem[a[10:2]];
        if (hi) return w;
        if (lo) return {16'h0, w[16*(a[1] ^ en) +: 16]};
        return {24'h0, w[8*(a[1:0] ^ {en, en}) +: 8]};
    endfunction

    function automatic logic [10:0] pick();
        logic [8:0] w;
        w = 9'($urandom % 8);
        if (w == 9'h007) w = 9'h1ff;
        return {w, 2'($urandom)};
    endfunction

    // ----------------------------------------
    // Checks and transfers
    // ----------------------------------------
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic access(input logic wr, input logic [10:0] a, input logic [3:0] be);
        logic [31:0] d;
        int n;
        d = $urandom;
        n = 0;
        req_write = wr;
        req_addr = a;
        req_be = be;
        req_wdata = d;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
        chk("rsp_cycles", 32'(hbp_pkg::ACC_CYC), 32'(n));
        if (!wr) begin
            chk("rsp_rdata", model_rd(a), rsp_rdata);
        end else begin
            model_wr(a, be, d);
            n = 0;
            while (user_wr_pulse !== 1'b1 && n < 30) begin
                @(negedge clk);
                n++;
            end
            chk("user_wr_addr", {23'h0, a[10:2]}, {23'h0, user_wr_addr});
            user_addr = a[10:2];
            repeat (2) @(negedge clk);
            chk("user_rdata", exp_mem[a[10:2]], user_rdata);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [2:0]  tab [6];
        logic [10:0] a;
        logic [3:0]  be;
        tab = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h0, 3'h1};
        void'($urandom(70357));
        for (int c = 0; c < 6; c++) begin
            nrst = 1'b0;
            {hi, lo, en} = tab[c];
            repeat (2) @(negedge clk);
            nrst = 1'b1;
            for (int w = 0; w < 8 && c == 0; w++) begin
                access(1'b1, {(w == 7) ? 9'h1ff : 9'(w), 2'h0}, 4'hf);
            end
            for (int k = 0; k < 24; k++) begin
                if (k % 3 != 1) a = pick();
                be = 4'($urandom);
                if ((be & (hi ? 4'hf : (lo ? 4'h3 : 4'h1))) == 4'h0) be = 4'h1;
                access(k % 3 == 0, a, be);
            end
            chk("user_mode", hi ? 32'h2 : (lo ? 32'h1 : 32'h0),
                {30'h0, user_mode});
        end
        final_report();
    end

endmodule // tb

`default_nettype wire
